// ---- core/sdm_ctrl_pkg.sv ----
// constants for the delta-sigma modulator and test DAC mode controller
// assumes a 100 MHz system clock that samples the master clock as an input
package sdm_ctrl_pkg;
	localparam logic [2:0] MODE_MOD = 3'h0;
	localparam logic [2:0] MODE_AC_BOTH = 3'h1;
	localparam logic [2:0] MODE_AC_PREC = 3'h2;
	localparam logic [2:0] MODE_AC_BUF = 3'h3;
	localparam logic [2:0] MODE_DC_CM = 3'h4;
	localparam logic [2:0] MODE_DC_DIFF = 3'h5;
	localparam logic [2:0] MODE_AC_CM = 3'h6;
	localparam logic [2:0] MODE_SLEEP = 3'h7;
	localparam logic [2:0] ATT_SMALLEST = 3'h6;
	localparam logic [2:0] KIND_NONE = 3'h0;
	localparam logic [2:0] KIND_AC_DIFF = 3'h1;
	localparam logic [2:0] KIND_AC_CM = 3'h2;
	localparam logic [2:0] KIND_DC_CM = 3'h3;
	localparam logic [2:0] KIND_DC_DIFF = 3'h4;
	localparam logic [1:0] MOD_DIV_LAST = 2'h3;
	localparam logic [2:0] TBS_DIV_LAST = 3'h7;
	localparam logic [5:0] RECOVER_TICKS = 6'h20;
	localparam logic [6:0] UNSTABLE_HOLD_TICKS = 7'h40;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOSS_TIME_NS = 40000;
	localparam logic [11:0] LOSS_CYCLES = 12'((LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic signed [17:0] MOD_REF = 18'sh08000;
	localparam logic signed [17:0] OVR_LIMIT = 18'sh060c5;
	localparam logic signed [17:0] ACC_CLAMP = 18'sh10000;
	localparam logic [11:0] LEVEL_MID = 12'h800;
	localparam logic [11:0] LEVEL_MAX = 12'hfff;
	localparam logic [11:0] DC_CM_LEVEL = 12'h800;
	localparam logic [11:0] DC_DIFF_LEVEL = 12'hfff;
	localparam int FIFO_WIDTH = 1;
	localparam int FIFO_DEPTH = 16;
endpackage : sdm_ctrl_pkg

// ---- core/sigma_delta_mode_control.sv ----
// mode controller for a delta-sigma modulator with a built-in test DAC
// assumes the master clock, sync, mode pins and test stream are synchronous to CLK
`timescale 1ns/1ps
`default_nettype none
module sigma_delta_mode_control
	import sdm_ctrl_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// master clock and sync from the decimation filter
	input wire logic MASTER_CLK_IN,
	input wire logic SAMPLE_SYNC_IN,
	// mode and attenuation pins
	input wire logic MODE_SELECT_BIT2,
	input wire logic MODE_SELECT_BIT1,
	input wire logic MODE_SELECT_BIT0,
	input wire logic [2:0] ATTENUATION_SELECT,
	// digitised modulator input
	input wire logic signed [15:0] ANALOG_IN,
	// test stream
	input wire logic TEST_PATTERN_STREAM,
	input wire logic TEST_PATTERN_VALID,
	output logic TEST_PATTERN_READY,
	// modulator outputs, enables low while driving
	output logic MOD_BITSTREAM_OUT,
	output logic MOD_BITSTREAM_OE_N,
	output logic INSTABILITY_FLAG,
	output logic INSTABILITY_FLAG_OE_N,
	// test outputs, enables low while driving
	output logic PRECISION_OE_N,
	output logic BUFFERED_OE_N,
	output logic [2:0] TEST_KIND,
	output logic [11:0] TEST_LEVEL,
	// status
	output logic POWER_DOWN
);
	typedef enum logic {ST_FOURTH, ST_FIRST} order_e;

	logic mclk_q;
	logic tick;
	logic [11:0] idle_cnt;
	logic power_down;
	logic [2:0] mode;
	logic sync_prev;
	logic sync_rise;
	logic [1:0] div_cnt;
	logic bit_en;
	logic running;
	logic signed [17:0] acc;
	logic signed [17:0] next_acc;
	logic signed [17:0] in_ext;
	logic mod_bit;
	logic over_range;
	order_e order;
	logic [5:0] inrange_cnt;
	logic [6:0] hold_cnt;
	logic ac_mode;
	logic [2:0] tbs_cnt;
	logic tbs_en;
	logic fifo_valid;
	logic fifo_bit;
	logic drain;
	logic [11:0] ac_level;
	logic [11:0] next_kind_level;
	logic [2:0] next_kind;
	logic next_prec_oe_n;
	logic next_buf_oe_n;

	// master clock edge becomes a one-cycle enable
	always_ff @(posedge CLK) begin
		if (RST) begin
			mclk_q <= 1'b0;
		end else begin
			mclk_q <= MASTER_CLK_IN;
		end
	end
	assign tick = MASTER_CLK_IN && !mclk_q;

	// loss-of-clock detector
	always_ff @(posedge CLK) begin
		if (RST) begin
			idle_cnt <= '0;
			power_down <= 1'b1;
		end else if (tick) begin
			idle_cnt <= '0;
			power_down <= 1'b0;
		end else if (idle_cnt >= LOSS_CYCLES) begin
			power_down <= 1'b1;
		end else begin
			idle_cnt <= idle_cnt + 1'b1;
		end
	end

	// mode pins sampled on master clock edges
	always_ff @(posedge CLK) begin
		if (RST) begin
			mode <= MODE_SLEEP;
		end else if (tick) begin
			mode <= {MODE_SELECT_BIT2, MODE_SELECT_BIT1, MODE_SELECT_BIT0};
		end
	end

	assign running = !power_down && mode != MODE_SLEEP;

	// conversion divider, restarted by sync
	always_ff @(posedge CLK) begin
		if (RST) begin
			sync_prev <= 1'b0;
		end else if (tick) begin
			sync_prev <= SAMPLE_SYNC_IN;
		end
	end
	assign sync_rise = tick && SAMPLE_SYNC_IN && !sync_prev;

	always_ff @(posedge CLK) begin
		if (RST) begin
			div_cnt <= '0;
		end else if (sync_rise) begin
			div_cnt <= '0;
		end else if (tick) begin
			div_cnt <= div_cnt + 1'b1;
		end
	end
	assign bit_en = tick && !sync_rise && div_cnt == MOD_DIV_LAST && running;

	// error-feedback loop: full scale sits at 0.756 of the reference
	assign in_ext = 18'(ANALOG_IN);
	assign over_range = in_ext > OVR_LIMIT || in_ext < -OVR_LIMIT;

	always_comb begin
		next_acc = acc + in_ext + (mod_bit ? -MOD_REF : MOD_REF);
		// collapsed loop keeps its integrator bounded
		if (order == ST_FIRST && next_acc > ACC_CLAMP) begin
			next_acc = ACC_CLAMP;
		end else if (order == ST_FIRST && next_acc < -ACC_CLAMP) begin
			next_acc = -ACC_CLAMP;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			acc <= '0;
			mod_bit <= 1'b0;
		end else if (!running) begin
			acc <= '0;
			mod_bit <= 1'b0;
		end else if (bit_en) begin
			acc <= next_acc;
			mod_bit <= !next_acc[17];
		end
	end

	// stability supervisor
	always_ff @(posedge CLK) begin
		if (RST) begin
			order <= ST_FOURTH;
			inrange_cnt <= '0;
			hold_cnt <= '0;
		end else if (!running) begin
			order <= ST_FOURTH;
			inrange_cnt <= '0;
			hold_cnt <= '0;
		end else if (tick) begin
			case (order)
				ST_FOURTH: begin
					inrange_cnt <= '0;
					hold_cnt <= '0;
					if (over_range) begin
						order <= ST_FIRST;
					end
				end
				ST_FIRST: begin
					if (over_range) begin
						inrange_cnt <= '0;
						hold_cnt <= hold_cnt + 1'b1;
						if (hold_cnt == UNSTABLE_HOLD_TICKS - 1'b1) begin
							order <= ST_FOURTH;
						end
					end else begin
						inrange_cnt <= inrange_cnt + 1'b1;
						if (inrange_cnt == RECOVER_TICKS - 1'b1) begin
							order <= ST_FOURTH;
						end
					end
				end
				default: begin
					order <= ST_FOURTH;
				end
			endcase
		end
	end

	// modulator pin drivers
	always_ff @(posedge CLK) begin
		if (RST) begin
			MOD_BITSTREAM_OUT <= 1'b0;
			MOD_BITSTREAM_OE_N <= 1'b1;
			INSTABILITY_FLAG <= 1'b0;
			INSTABILITY_FLAG_OE_N <= 1'b1;
			POWER_DOWN <= 1'b1;
		end else begin
			MOD_BITSTREAM_OUT <= mod_bit;
			MOD_BITSTREAM_OE_N <= !running;
			INSTABILITY_FLAG <= running && order == ST_FIRST;
			INSTABILITY_FLAG_OE_N <= !running;
			POWER_DOWN <= power_down;
		end
	end

	// test stream path
	assign ac_mode = running && (mode == MODE_AC_BOTH || mode == MODE_AC_PREC ||
		mode == MODE_AC_BUF || mode == MODE_AC_CM);

	always_ff @(posedge CLK) begin
		if (RST) begin
			tbs_cnt <= '0;
		end else if (sync_rise) begin
			tbs_cnt <= '0;
		end else if (tick) begin
			tbs_cnt <= tbs_cnt + 1'b1;
		end
	end
	// stream bits are consumed at one eighth of the master rate
	assign tbs_en = tick && tbs_cnt == TBS_DIV_LAST;
	assign drain = ac_mode && tbs_en;

	stream_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(TEST_PATTERN_VALID),
		.in_data(TEST_PATTERN_STREAM),
		.in_ready(TEST_PATTERN_READY),
		.out_valid(fifo_valid),
		.out_data(fifo_bit),
		.out_ready(drain)
	);

	// one-bit DAC: first-order smoothing of the ones density
	always_ff @(posedge CLK) begin
		if (RST) begin
			ac_level <= LEVEL_MID;
		end else if (!ac_mode) begin
			ac_level <= LEVEL_MID;
		end else if (drain && fifo_valid) begin
			if (fifo_bit) begin
				ac_level <= ac_level + ((LEVEL_MAX - ac_level) >> 4);
			end else begin
				ac_level <= ac_level - (ac_level >> 4);
			end
		end
	end

	always_comb begin
		next_kind = KIND_NONE;
		next_kind_level = LEVEL_MID;
		next_prec_oe_n = 1'b1;
		next_buf_oe_n = 1'b1;
		if (running) begin
			case (mode)
				MODE_MOD: begin
					next_kind = KIND_NONE;
				end
				MODE_AC_BOTH: begin
					next_kind = KIND_AC_DIFF;
					next_kind_level = ac_level;
					next_prec_oe_n = 1'b0;
					next_buf_oe_n = 1'b0;
				end
				MODE_AC_PREC: begin
					next_kind = KIND_AC_DIFF;
					next_kind_level = ac_level;
					next_prec_oe_n = 1'b0;
				end
				MODE_AC_BUF: begin
					next_kind = KIND_AC_DIFF;
					next_kind_level = ac_level;
					next_buf_oe_n = 1'b0;
				end
				MODE_DC_CM: begin
					next_kind = KIND_DC_CM;
					next_kind_level = DC_CM_LEVEL;
					next_prec_oe_n = 1'b0;
					next_buf_oe_n = 1'b0;
				end
				MODE_DC_DIFF: begin
					next_kind = KIND_DC_DIFF;
					next_kind_level = DC_DIFF_LEVEL;
					next_prec_oe_n = 1'b0;
					next_buf_oe_n = 1'b0;
				end
				MODE_AC_CM: begin
					next_kind = KIND_AC_CM;
					next_prec_oe_n = 1'b0;
					next_buf_oe_n = 1'b0;
					// smallest attenuation gives a flat common-mode level
					next_kind_level = (ATTENUATION_SELECT == ATT_SMALLEST) ?
						LEVEL_MID : ac_level;
				end
				default: begin
					next_kind = KIND_NONE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			TEST_KIND <= KIND_NONE;
			TEST_LEVEL <= LEVEL_MID;
			PRECISION_OE_N <= 1'b1;
			BUFFERED_OE_N <= 1'b1;
		end else begin
			TEST_KIND <= next_kind;
			TEST_LEVEL <= next_kind_level;
			PRECISION_OE_N <= next_prec_oe_n;
			BUFFERED_OE_N <= next_buf_oe_n;
		end
	end

	// checks
	sequence s_detect;
		tick && running && order == ST_FOURTH && over_range;
	endsequence
	sequence s_flag_up;
		order == ST_FIRST ##1 INSTABILITY_FLAG;
	endsequence

	property p_sleep_hiz;
		@(posedge CLK) disable iff (RST)
		mode == MODE_SLEEP |=> MOD_BITSTREAM_OE_N && INSTABILITY_FLAG_OE_N &&
			PRECISION_OE_N && BUFFERED_OE_N;
	endproperty
	a_sleep_hiz: assert property (p_sleep_hiz) else $error("sleep left a pin driven");

	property p_power_down;
		@(posedge CLK) disable iff (RST)
		!tick [*8] ##0 idle_cnt >= LOSS_CYCLES |-> ##2 POWER_DOWN && MOD_BITSTREAM_OE_N;
	endproperty
	a_power_down: assert property (p_power_down) else $error("no power down on lost clock");

	property p_mod_mode;
		@(posedge CLK) disable iff (RST)
		running && mode == MODE_MOD |=> !MOD_BITSTREAM_OE_N && PRECISION_OE_N &&
			BUFFERED_OE_N;
	endproperty
	a_mod_mode: assert property (p_mod_mode) else $error("modulator mode pin state wrong");

	property p_ac_prec_only;
		@(posedge CLK) disable iff (RST)
		running && mode == MODE_AC_PREC |=> !PRECISION_OE_N && BUFFERED_OE_N &&
			TEST_KIND == KIND_AC_DIFF;
	endproperty
	a_ac_prec_only: assert property (p_ac_prec_only) else $error("mode 2 enables wrong");

	property p_ac_buf_only;
		@(posedge CLK) disable iff (RST)
		running && mode == MODE_AC_BUF |=> PRECISION_OE_N && !BUFFERED_OE_N;
	endproperty
	a_ac_buf_only: assert property (p_ac_buf_only) else $error("mode 3 enables wrong");

	property p_ac_cm_flat;
		@(posedge CLK) disable iff (RST)
		running && mode == MODE_AC_CM && ATTENUATION_SELECT == ATT_SMALLEST |=>
			TEST_LEVEL == LEVEL_MID && TEST_KIND == KIND_AC_CM;
	endproperty
	a_ac_cm_flat: assert property (p_ac_cm_flat) else $error("common mode not flat");

	property p_sync_restart;
		@(posedge CLK) disable iff (RST)
		sync_rise |=> div_cnt == 2'h0;
	endproperty
	a_sync_restart: assert property (p_sync_restart) else $error("sync did not restart");

	property p_flag_raise;
		@(posedge CLK) disable iff (RST)
		s_detect ##1 running |-> s_flag_up;
	endproperty
	a_flag_raise: assert property (p_flag_raise) else $error("flag not raised");

	property p_recover;
		@(posedge CLK) disable iff (RST)
		running && order == ST_FIRST ##1 order == ST_FOURTH && running |->
			$past(inrange_cnt) == RECOVER_TICKS - 1'b1 ||
			$past(hold_cnt) == UNSTABLE_HOLD_TICKS - 1'b1;
	endproperty
	a_recover: assert property (p_recover) else $error("left first order early");

	property p_bit_rate;
		@(posedge CLK) disable iff (RST)
		$changed(MOD_BITSTREAM_OUT) |-> $past(bit_en, 2) || $past(!running, 2);
	endproperty
	a_bit_rate: assert property (p_bit_rate) else $error("bitstream moved outside a slot");
endmodule : sigma_delta_mode_control
`default_nettype wire

// ---- core/stream_fifo.sv ----
// synchronous FIFO with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	logic [AW:0] next_count;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= next_count;
			// registered ready: full is known one cycle ahead from next_count
			in_ready <= next_count != (AW+1)'(DEPTH);
		end
	end
endmodule : stream_fifo
`default_nettype wire

// ---- tb/decimation_filter_model.sv ----
// behavioural decimation filter: master clock, sync and test stream
// assumes the device samples these lines on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module decimation_filter_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// requests from the bench
	input wire logic run,
	input wire logic sync_req,
	input wire logic pat_bit,
	input wire logic pat_en,
	// lines to the device
	output logic master_clk,
	output logic sample_sync,
	output logic stream_bit,
	output logic stream_valid,
	input wire logic stream_ready,
	output int pushed
);
	logic [1:0] phase = 2'h0;
	logic took = 1'b0;
	initial begin
		master_clk = 1'b0;
		sample_sync = 1'b0;
		stream_bit = 1'b0;
		stream_valid = 1'b0;
		pushed = 0;
	end
	// four system cycles per master cycle, stands low while stopped
	always @(negedge clk) begin
		phase <= run ? phase + 2'h1 : 2'h0;
		master_clk <= run && (phase == 2'h1 || phase == 2'h2);
		if (run && phase == 2'h1)
			sample_sync <= sync_req;
		// a bit stands until taken; an idle line flips every cycle
		if (rst)
			stream_valid <= 1'b0;
		else if (!stream_valid || took) begin
			stream_valid <= pat_en;
			stream_bit <= pat_en ? pat_bit : ~stream_bit;
		end
	end
	always @(posedge clk) begin
		// ready paces the source down to the device's drain rate
		took <= stream_valid & stream_ready;
		if (stream_valid & stream_ready)
			pushed <= pushed + 1;
	end
endmodule : decimation_filter_model
`default_nettype wire

// ---- tb/sigma_delta_mode_control_bench.sv ----
// self-checking bench for the mode controller, filter model on its far side
// assumes the package, the stream FIFO and the controller are compiled first
`timescale 1ns/1ps
`default_nettype none
module sigma_delta_mode_control_bench
	import sdm_ctrl_pkg::*;
;
	typedef struct {logic [2:0] mode; logic [6:0] want;} row_s;
	typedef struct {logic signed [15:0] level; int lo; int hi;} dens_s;
	// want: precision_n, buffered_n, kind, bitstream_n, flag_n
	row_s rows [8] = '{'{3'h0, 7'h60}, '{3'h1, 7'h04}, '{3'h2, 7'h24}, '{3'h3, 7'h44},
		'{3'h4, 7'h0c}, '{3'h5, 7'h10}, '{3'h6, 7'h08}, '{3'h7, 7'h63}};
	// ones counted over 256 bits
	dens_s dens [3] = '{'{16'sh0000, 115, 141}, '{16'sh5c29, 205, 235}, '{-16'sh5c29, 20, 51}};
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [2:0] mode = 3'h7;
	logic [2:0] attenuation_select = 3'h0;
	logic signed [15:0] ain = 16'sh0000;
	logic run = 1'b0;
	logic sync_req = 1'b0;
	logic pat_bit = 1'b0;
	logic pat_en = 1'b0;
	logic mclk, sync, tbit, tvalid, tready, mbit, mbit_n, flag, flag_n, prec_n, buf_n, pdown;
	logic [2:0] kind;
	logic [11:0] level;
	logic m_prev = 1'b0, s_prev = 1'b0, f_prev = 1'b0, b_prev = 1'b0, measuring = 1'b0;
	int pushed, cyc = 0, sync_cyc = 0, ones = 0, rises = 0, err_total = 0, checks = 0;

	decimation_filter_model decimation_filter_model_inst (
		.clk(CLK), .rst(RST), .run(run), .sync_req(sync_req), .pat_bit(pat_bit),
		.pat_en(pat_en), .master_clk(mclk), .sample_sync(sync), .stream_bit(tbit),
		.stream_valid(tvalid), .stream_ready(tready), .pushed(pushed)
	);
	sigma_delta_mode_control sigma_delta_mode_control_inst (
		.CLK(CLK), .RST(RST), .MASTER_CLK_IN(mclk), .SAMPLE_SYNC_IN(sync),
		.MODE_SELECT_BIT2(mode[2]), .MODE_SELECT_BIT1(mode[1]), .MODE_SELECT_BIT0(mode[0]),
		.ATTENUATION_SELECT(attenuation_select), .ANALOG_IN(ain), .TEST_PATTERN_STREAM(tbit),
		.TEST_PATTERN_VALID(tvalid), .TEST_PATTERN_READY(tready), .MOD_BITSTREAM_OUT(mbit),
		.MOD_BITSTREAM_OE_N(mbit_n), .INSTABILITY_FLAG(flag), .INSTABILITY_FLAG_OE_N(flag_n),
		.PRECISION_OE_N(prec_n), .BUFFERED_OE_N(buf_n), .TEST_KIND(kind), .TEST_LEVEL(level),
		.POWER_DOWN(pdown)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic conclude;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	task automatic cycles(input int n);
		repeat (n) @(negedge CLK);
	endtask : cycles

	always #5 CLK = ~CLK;

	// tick and sync tracking, bit sampling five cycles into each slot, flag edge counting
	always @(posedge CLK) begin
		cyc++;
		if (mclk && !m_prev) begin
			if (sync && !s_prev)
				sync_cyc = cyc;
			s_prev = sync;
		end
		m_prev = mclk;
		if (measuring && (cyc - sync_cyc) % 16 == 5)
			ones += int'(mbit === 1'b1);
		if (flag === 1'b1 && !f_prev)
			rises++;
		f_prev = (flag === 1'b1);
	end

	// bit slots stay aligned to the last sync
	always @(negedge CLK) begin
		if (measuring && mbit !== b_prev)
			// the pin follows the slot's tick edge by one cycle
			check(16'((cyc - sync_cyc) % 16 == 1), 16'h1);
		b_prev = mbit;
	end

	initial begin
		cycles(60000);
		err_total++;
		conclude();
	end

	initial begin
		cycles(16);
		check(16'({pdown, prec_n, buf_n, mbit_n, flag_n, tready, kind}), 16'h01f0);
		check(16'(level), 16'h0800);
		RST = 1'b0;
		run = 1'b1;
		cycles(4);
		foreach (rows[i]) begin
			mode = rows[i].mode;
			cycles(16);
			check(16'({prec_n, buf_n, kind, mbit_n, flag_n}), 16'(rows[i].want));
		end
		mode = MODE_MOD;
		cycles(16);
		rises = 0;
		foreach (dens[i]) begin
			ain = dens[i].level;
			sync_req = 1'b1;
			cycles(8);
			sync_req = 1'b0;
			cycles(32);
			ones = 0;
			measuring = 1'b1;
			cycles(4096);
			measuring = 1'b0;
			check(16'(ones >= dens[i].lo && ones <= dens[i].hi), 16'h1);
		end
		check(16'(rises), 16'h0);
		ain = 16'sh7530;
		cycles(40);
		check(16'(flag), 16'h1);
		ain = 16'sh0000;
		cycles(120);
		check(16'(flag), 16'h1);
		cycles(32);
		check(16'(flag), 16'h0);
		rises = 0;
		ain = -16'sh7530;
		cycles(1200);
		check(16'(rises >= 2), 16'h1);
		ain = 16'sh0000;
		cycles(200);
		// fill while nothing drains, then drain with the source stalled
		mode = MODE_DC_CM;
		pat_bit = 1'b1;
		pat_en = 1'b1;
		cycles(60);
		check(16'({tready, 5'(pushed)}), 16'h0010);
		pat_en = 1'b0;
		mode = MODE_AC_BOTH;
		cycles(700);
		check(16'({tready, level > 12'h800}), 16'h0003);
		pat_bit = 1'b0;
		mode = MODE_SLEEP;
		cycles(16);
		pat_en = 1'b1;
		mode = MODE_AC_BOTH;
		cycles(700);
		check(16'(level < 12'h800), 16'h1);
		attenuation_select = ATT_SMALLEST;
		mode = MODE_AC_CM;
		pat_bit = 1'b1;
		cycles(700);
		check(16'({prec_n, buf_n, level}), 16'h0800);
		attenuation_select = 3'h0;
		cycles(700);
		check(16'(level > 12'h800), 16'h1);
		run = 1'b0;
		cycles(3900);
		check(16'(pdown), 16'h0);
		cycles(200);
		check(16'({pdown, prec_n, buf_n, mbit_n}), 16'h000f);
		run = 1'b1;
		cycles(20);
		check(16'({pdown, prec_n}), 16'h0);
		// a pin change that falls between two ticks is never taken
		mode = MODE_MOD;
		cycles(16);
		@(posedge mclk);
		@(negedge CLK);
		mode = MODE_AC_BOTH;
		@(negedge CLK);
		mode = MODE_MOD;
		repeat (12) begin
			@(negedge CLK);
			check(16'(prec_n), 16'h1);
		end
		conclude();
	end
endmodule : sigma_delta_mode_control_bench
`default_nettype wire
